// File: include/fpt_defines.svh
// Offsets, field positions, reset values and timing counts of the flash protect and timing block.
`ifndef FPT_DEFINES_SVH
`define FPT_DEFINES_SVH
`define FPT_ADDR_COMMAND 8'h01
`define FPT_ADDR_PAGE_SECTOR 8'h02
`define FPT_ADDR_TIMING_HIGH 8'h03
`define FPT_ADDR_TIMING_LOW 8'h04
`define FPT_CMD_UNLOCK1 8'h73
`define FPT_CMD_UNLOCK2 8'h8c
`define FPT_CMD_PAGE_ERASE 8'h95
`define FPT_CMD_MASS_ERASE 8'h63
`define FPT_CMD_SECTOR_SELECT 8'h5e
`define FPT_STATE_LOCKED 6'h00
`define FPT_STATE_FIRST 6'h01
`define FPT_STATE_SECOND 6'h02
`define FPT_STATE_UNLOCKED 6'h03
`define FPT_STATE_SECTOR_SEL 6'h04
`define FPT_STATE_PROGRAM 6'h08
`define FPT_STATE_PAGE_ERASE 6'h10
`define FPT_STATE_MASS_ERASE 6'h20
`define FPT_SECTOR_GUARD_RESET 8'h00
`define FPT_PAGE_SELECT_RESET 8'h00
`define FPT_TIMING_RESET 8'h00
`define FPT_INFO_PAGE3_SELECT 8'h83
`define FPT_IFEN_BIT 7
`define FPT_PROGRAM_TIME_US 30
`define FPT_ERASE_TIME_MS 10
`define FPT_INFO_PAGE 2'h3
`endif

// File: include/fpt_pkg.sv
// Types shared by the flash protect and timing block.
package fpt_pkg;
	typedef enum logic [1:0] {
		FPT_SRC_CPU = 2'h0,
		FPT_SRC_SERIAL = 2'h1,
		FPT_SRC_BYTEPORT = 2'h2
	} fpt_source_t;
	typedef enum logic [1:0] {
		FPT_OP_READ = 2'h0,
		FPT_OP_PROGRAM = 2'h1,
		FPT_OP_PAGE_ERASE = 2'h2,
		FPT_OP_MASS_ERASE = 2'h3
	} fpt_op_t;
	typedef enum logic [2:0] {
		FPT_LOCKED = 3'b000,
		FPT_FIRST = 3'b001,
		FPT_SECOND = 3'b011,
		FPT_UNLOCKED = 3'b010,
		FPT_SECTOR_SEL = 3'b110,
		FPT_BUSY = 3'b100
	} fpt_state_t;
endpackage : fpt_pkg

// File: hdl/fpt_access_check.sv
// Permission matrix for flash accesses by CPU, serial port and byte programming port.
`timescale 1ns/1ps
`include "fpt_defines.svh"
module fpt_access_check
	import fpt_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int SECTORS = 8
) (
	// Request description.
	input wire fpt_source_t source,
	input wire fpt_op_t op,
	input wire logic infoArea,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [1:0] infoPage,
	// Protection state.
	input wire logic [SECTORS-1:0] sectorGuardBits,
	input wire logic wholeMemoryGuardBit,
	input wire logic lowerHalfGuardBit,
	// Verdict.
	output logic allow
);
	if (ADDR_W < 8 || SECTORS < 1 || SECTORS > 8) begin : g_bad_params
		$error("fpt_access_check: unsupported parameters");
	end
	localparam int SECT_SHIFT = ADDR_W - 3;
	logic [2:0] sector;
	logic upperHalf;
	logic sectorHit;
	logic isWrite;
	assign sector = addr[ADDR_W-1:SECT_SHIFT];
	assign upperHalf = addr[ADDR_W-1];
	assign sectorHit = (32'(sector) < SECTORS) ? sectorGuardBits[sector] : 1'b0;
	assign isWrite = (op == FPT_OP_PROGRAM) || (op == FPT_OP_PAGE_ERASE);
	always_comb begin
		allow = 1'b0;
		case (source)
			FPT_SRC_CPU: begin
				// Option guard bits play no part for the CPU; the sector guard silently drops writes.
				allow = !infoArea && op != FPT_OP_MASS_ERASE && !(isWrite && sectorHit);
			end
			FPT_SRC_SERIAL: begin
				if (infoArea) begin
					allow = infoPage == `FPT_INFO_PAGE && op != FPT_OP_MASS_ERASE &&
						!(isWrite && (!wholeMemoryGuardBit || !lowerHalfGuardBit));
				end else if (op == FPT_OP_MASS_ERASE) begin
					allow = 1'b1;
				end else begin
					// Sector guard bits are ignored on this path.
					allow = wholeMemoryGuardBit && (lowerHalfGuardBit || upperHalf);
				end
			end
			FPT_SRC_BYTEPORT: begin
				if (op == FPT_OP_MASS_ERASE) begin
					allow = 1'b1;
				end else if (infoArea) begin
					allow = infoPage == `FPT_INFO_PAGE &&
						(op == FPT_OP_READ || (wholeMemoryGuardBit && lowerHalfGuardBit));
				end else begin
					allow = wholeMemoryGuardBit && (lowerHalfGuardBit || upperHalf);
				end
			end
			default: begin
				allow = 1'b0;
			end
		endcase
	end
endmodule : fpt_access_check

// File: hdl/fpt_flash_guard.sv
// Sector guard, timing value, command selection and access qualification of the flash controller.
`timescale 1ns/1ps
`include "fpt_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Writing 5EH to command register while locked selects the sector guard register.
// - Without that selection, writes at the shared location go to page select.
// - With the sector guard register selected, status reports 000100.
// - Eight guard bits; a set bit blocks CPU program and page erase there.
// - Serial-port program and page erase ignore the sector guard bits.
// - All guard bits reset to 0, unprotected.
// - A set guard bit cannot be cleared by writes, only by power-down.
// - Each bit guards 16 pages; small variant uses only bits 3-0.
// - High and low timing bytes form a 16-bit kHz timing value.
// - Timing value yields about 30 us program and 10 ms erase times.
// - CPU may program, read, page erase main memory only; guard options ignored.
// - Serial port: all main ops; lower-half and whole guards block reads and writes.
// - Serial port info area: page 3 only, no mass erase; guards block writes.
// - Byte port drives array controls directly from registered pin values.
// - CPU clock stops while serial mode and byte port are both active.
// - Byte port may always mass erase; guards clear only after mass erase.
// - Byte port with only lower-half guard low: upper half of main memory only.
// - Byte port info accesses always pass the page check as page 3, whatever the address; guarded page is read-only.
module fpt_flash_guard
	import fpt_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int SECTORS = 8,
	parameter logic SMALL_VARIANT = 1'b0,
	parameter int PIN_W = 28
) (
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// Register file port from the CPU or serial programming port.
	input wire logic regWrite,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire fpt_source_t regSource,
	output logic [7:0] regRdata,
	// Flash request from the CPU or serial programming port.
	input wire logic reqValid,
	input wire fpt_op_t reqOp,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic [7:0] reqWdata,
	output logic reqAccept,
	output logic reqDropped,
	// Option guard bits, active low.
	input wire logic wholeMemoryGuardBit,
	input wire logic lowerHalfGuardBit,
	// Serial programming mode and byte port enable.
	input wire logic serialModeActive,
	input wire logic bytePortEnable,
	input wire logic [PIN_W-1:0] bytePortPins,
	output logic cpuClockStop,
	// Flash array control.
	output logic arrayStrobe,
	output fpt_op_t arrayOp,
	output logic [ADDR_W-1:0] arrayAddr,
	output logic [7:0] arrayWdata,
	output logic arrayInfo,
	output logic [15:0] flashTimingValue,
	output logic [15:0] programCycles,
	output logic [23:0] eraseCycles
);
	// Pins carry address, data, info flag, two operation bits and the strobe, so narrower widths cannot work.
	if (PIN_W < ADDR_W + 8 + 4 || ADDR_W < 8) begin : g_bad_pins
		$error("fpt_flash_guard: byte port pins too narrow");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers and command state.
	fpt_state_t state, next_state;
	logic [7:0] sectorGuardBits, next_sectorGuardBits;
	logic [7:0] pageSelectReg, next_pageSelectReg;
	logic [7:0] timingHigh, next_timingHigh;
	logic [7:0] timingLow, next_timingLow;
	logic [5:0] busyCode, next_busyCode;
	logic [7:0] usableMask;
	logic [5:0] flashStateReg;

	// The small variant has only four sectors, so the upper guard bits are tied off.
	assign usableMask = SMALL_VARIANT ? 8'h0f : 8'hff;

	always_comb begin
		next_state = state;
		next_sectorGuardBits = sectorGuardBits;
		next_pageSelectReg = pageSelectReg;
		next_timingHigh = timingHigh;
		next_timingLow = timingLow;
		next_busyCode = busyCode;
		if (regWrite) begin
			case (regAddr)
				`FPT_ADDR_COMMAND: begin
					case (state)
						FPT_LOCKED: begin
							if (regWdata == `FPT_CMD_UNLOCK1) begin
								next_state = FPT_FIRST;
							end else if (regWdata == `FPT_CMD_SECTOR_SELECT) begin
								next_state = FPT_SECTOR_SEL;
							end
						end
						FPT_FIRST: begin
							next_state = (regWdata == `FPT_CMD_UNLOCK2) ? FPT_SECOND : FPT_LOCKED;
						end
						FPT_SECOND: begin
							next_state = FPT_UNLOCKED;
						end
						default: begin
							next_state = FPT_LOCKED;
						end
					endcase
				end
				`FPT_ADDR_PAGE_SECTOR: begin
					if (state == FPT_SECTOR_SEL) begin
						// Bits only ever accumulate; a zero write leaves set bits standing.
						next_sectorGuardBits = sectorGuardBits | (regWdata & usableMask);
						next_state = FPT_LOCKED;
					end else begin
						next_pageSelectReg = regWdata;
					end
				end
				`FPT_ADDR_TIMING_HIGH: begin
					next_timingHigh = regWdata;
				end
				`FPT_ADDR_TIMING_LOW: begin
					next_timingLow = regWdata;
				end
				default: begin
				end
			endcase
		end
		if (arrayStrobe) begin
			case (arrayOp)
				FPT_OP_PROGRAM: next_busyCode = `FPT_STATE_PROGRAM;
				FPT_OP_PAGE_ERASE: next_busyCode = `FPT_STATE_PAGE_ERASE;
				FPT_OP_MASS_ERASE: next_busyCode = `FPT_STATE_MASS_ERASE;
				default: next_busyCode = busyCode;
			endcase
		end else if (regWrite && regAddr == `FPT_ADDR_COMMAND) begin
			next_busyCode = 6'h00;
		end
	end

	// Only a power-on reset clears the guard bits.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= FPT_LOCKED;
			sectorGuardBits <= `FPT_SECTOR_GUARD_RESET;
			pageSelectReg <= `FPT_PAGE_SELECT_RESET;
			timingHigh <= `FPT_TIMING_RESET;
			timingLow <= `FPT_TIMING_RESET;
			busyCode <= 6'h00;
		end else if (clkEn) begin
			state <= next_state;
			sectorGuardBits <= next_sectorGuardBits;
			pageSelectReg <= next_pageSelectReg;
			timingHigh <= next_timingHigh;
			timingLow <= next_timingLow;
			busyCode <= next_busyCode;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status and register reads.
	always_comb begin
		case (state)
			FPT_LOCKED: flashStateReg = (busyCode != 6'h00) ? busyCode : `FPT_STATE_LOCKED;
			FPT_FIRST: flashStateReg = `FPT_STATE_FIRST;
			FPT_SECOND: flashStateReg = `FPT_STATE_SECOND;
			FPT_UNLOCKED: flashStateReg = `FPT_STATE_UNLOCKED;
			FPT_SECTOR_SEL: flashStateReg = `FPT_STATE_SECTOR_SEL;
			default: flashStateReg = `FPT_STATE_LOCKED;
		endcase
	end

	always_comb begin
		case (regAddr)
			`FPT_ADDR_COMMAND: regRdata = {2'b00, flashStateReg};
			`FPT_ADDR_PAGE_SECTOR: regRdata = (state == FPT_SECTOR_SEL) ? sectorGuardBits : pageSelectReg;
			`FPT_ADDR_TIMING_HIGH: regRdata = timingHigh;
			`FPT_ADDR_TIMING_LOW: regRdata = timingLow;
			default: regRdata = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Timing: the value holds the clock in kHz, so cycles = kHz * time.
	assign flashTimingValue = {timingHigh, timingLow};
	// 30 us at f kHz is f*30/1000 cycles; 10 ms is f*10 cycles.
	assign programCycles = 16'((32'(flashTimingValue) * `FPT_PROGRAM_TIME_US) / 1000);
	assign eraseCycles = 24'(32'(flashTimingValue) * `FPT_ERASE_TIME_MS);

	////////////////////////////////////////////////////////////////////////////////
	// Byte port pins: three-stage synchroniser, counted once stages two and three agree.
	logic [PIN_W-1:0] pinS1, pinS2, pinS3, pinHeld;
	logic [PIN_W-1:0] next_pinHeld;
	logic bytePortActive;

	assign bytePortActive = serialModeActive && bytePortEnable;
	assign cpuClockStop = bytePortActive;

	always_comb begin
		next_pinHeld = pinHeld;
		if (pinS2 == pinS3) begin
			next_pinHeld = pinS3;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinS1 <= '0;
			pinS2 <= '0;
			pinS3 <= '0;
			pinHeld <= '0;
		end else if (clkEn) begin
			pinS1 <= bytePortPins;
			pinS2 <= pinS1;
			pinS3 <= pinS2;
			pinHeld <= next_pinHeld;
		end
	end

	// Pin layout: address, data, info flag, operation, strobe.
	logic bpStrobe, bpInfo;
	fpt_op_t bpOp;
	logic [ADDR_W-1:0] bpAddr;
	logic [7:0] bpData;
	logic bpStrobeLast;
	assign bpAddr = pinHeld[ADDR_W-1:0];
	assign bpData = pinHeld[ADDR_W+7:ADDR_W];
	assign bpInfo = pinHeld[ADDR_W+8];
	assign bpOp = fpt_op_t'(pinHeld[ADDR_W+10:ADDR_W+9]);
	assign bpStrobe = pinHeld[ADDR_W+11];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bpStrobeLast <= 1'b0;
		end else if (clkEn) begin
			bpStrobeLast <= bpStrobe;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Access qualification.
	fpt_source_t chkSource;
	fpt_op_t chkOp;
	logic chkInfo;
	logic [ADDR_W-1:0] chkAddr;
	logic [7:0] chkData;
	logic chkValid;
	logic allow;
	logic [1:0] infoPage;

	always_comb begin
		if (bytePortActive) begin
			chkSource = FPT_SRC_BYTEPORT;
			chkOp = bpOp;
			chkInfo = bpInfo;
			chkAddr = bpAddr;
			chkData = bpData;
			chkValid = bpStrobe && !bpStrobeLast;
		end else begin
			chkSource = regSource;
			chkOp = reqOp;
			chkInfo = pageSelectReg[`FPT_IFEN_BIT];
			chkAddr = reqAddr;
			chkData = reqWdata;
			chkValid = reqValid;
		end
	end

	assign infoPage = chkInfo && chkSource != FPT_SRC_BYTEPORT ?
		((pageSelectReg == `FPT_INFO_PAGE3_SELECT) ? pageSelectReg[1:0] : 2'h0) : chkAddr[1:0] | 2'h0;

	fpt_access_check #(
		.ADDR_W(ADDR_W),
		.SECTORS(SECTORS)
	) u_check (
		.source(chkSource),
		.op(chkOp),
		.infoArea(chkInfo),
		.addr(chkAddr),
		.infoPage(chkSource == FPT_SRC_BYTEPORT ? `FPT_INFO_PAGE : infoPage),
		.sectorGuardBits(sectorGuardBits[SECTORS-1:0] & usableMask[SECTORS-1:0]),
		.wholeMemoryGuardBit(wholeMemoryGuardBit),
		.lowerHalfGuardBit(lowerHalfGuardBit),
		.allow(allow)
	);

	// CPU requests are refused while its clock is stopped.
	assign reqAccept = reqValid && !bytePortActive && allow;
	assign reqDropped = reqValid && !bytePortActive && !allow;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arrayStrobe <= 1'b0;
			arrayOp <= FPT_OP_READ;
			arrayAddr <= '0;
			arrayWdata <= 8'h00;
			arrayInfo <= 1'b0;
		end else if (clkEn) begin
			// Byte port values go straight to the array, bypassing the command sequence.
			arrayStrobe <= chkValid && allow;
			arrayOp <= chkOp;
			arrayAddr <= chkAddr;
			arrayWdata <= chkData;
			arrayInfo <= chkInfo;
		end
	end
endmodule : fpt_flash_guard

// File: verif/fpt_flash_array_model.sv
// Flash array model that records each strobe issued to it.
`timescale 1ns/1ps
module fpt_flash_array_model
	import fpt_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Array control.
	input wire logic arrayStrobe,
	input wire fpt_op_t arrayOp,
	input wire logic [ADDR_W-1:0] arrayAddr,
	input wire logic [7:0] arrayWdata,
	input wire logic arrayInfo,
	// Record of the last operation.
	output int count,
	output fpt_op_t lastOp,
	output logic [ADDR_W-1:0] lastAddr,
	output logic [7:0] lastData,
	output logic lastInfo
);
	// The controls are only meaningful under the strobe, so nothing is looked at between strobes.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 0;
		end else if (arrayStrobe) begin
			count <= count + 1;
			lastOp <= arrayOp;
			lastAddr <= arrayAddr;
			lastData <= arrayWdata;
			lastInfo <= arrayInfo;
		end
	end
endmodule : fpt_flash_array_model

// File: verif/fpt_flash_guard_chk.sv
// Port checker of the flash guard block.
`timescale 1ns/1ps
module fpt_flash_guard_chk
	import fpt_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Register port.
	input wire logic clkEn,
	input wire logic regWrite,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire fpt_source_t regSource,
	input wire logic [7:0] regRdata,
	// Requests.
	input wire logic reqValid,
	input wire fpt_op_t reqOp,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic reqAccept,
	input wire logic reqDropped,
	// Byte port, array and timing.
	input wire logic serialModeActive,
	input wire logic bytePortEnable,
	input wire logic cpuClockStop,
	input wire logic arrayStrobe,
	input wire fpt_op_t arrayOp,
	input wire logic [ADDR_W-1:0] arrayAddr,
	input wire logic [15:0] flashTimingValue,
	input wire logic [15:0] programCycles,
	input wire logic [23:0] eraseCycles
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence selWrite;
		regWrite && clkEn && regAddr == 8'h01 && regWdata == 8'h5e && regRdata == 8'h00;
	endsequence
	sequence selStatus;
		regAddr != 8'h01 || regRdata == 8'h04;
	endsequence
	sel_status_a: assert property (selWrite |=> selStatus) else $error("no select status");
	clock_stop_a: assert property (cpuClockStop == (serialModeActive && bytePortEnable)) else $error("stop");
	stop_refuse_a: assert property (cpuClockStop |-> !reqAccept) else $error("taken while stopped");
	accept_issue_a: assert property (reqValid && reqAccept && clkEn |=>
		arrayStrobe && arrayOp == $past(reqOp) && arrayAddr == $past(reqAddr))
		else $error("accepted not issued");
	drop_quiet_a: assert property (reqValid && reqDropped && clkEn && !cpuClockStop |=> !arrayStrobe)
		else $error("dropped but issued");
	drop_excl_a: assert property (!(reqAccept && reqDropped)) else $error("accept and drop");
	cpu_mass_a: assert property (reqValid && regSource == FPT_SRC_CPU && reqOp == FPT_OP_MASS_ERASE
		|-> !reqAccept) else $error("cpu mass erase");
	timing_high_a: assert property (regAddr == 8'h03 |-> regRdata == flashTimingValue[15:8]) else $error("high");
	timing_low_a: assert property (regWrite && clkEn && regAddr == 8'h04 |=>
		flashTimingValue[7:0] == $past(regWdata)) else $error("low");
	program_time_a: assert property (programCycles == 16'((32'(flashTimingValue) * 30) / 1000))
		else $error("program time");
	erase_time_a: assert property (eraseCycles == 24'(flashTimingValue) * 24'd10) else $error("erase time");
endmodule : fpt_flash_guard_chk
bind fpt_flash_guard fpt_flash_guard_chk #(.ADDR_W(ADDR_W)) fpt_flash_guard_chk_inst (.clk, .rst_n, .clkEn,
	.regWrite, .regAddr, .regWdata, .regSource, .regRdata, .reqValid, .reqOp, .reqAddr, .reqAccept, .reqDropped,
	.serialModeActive, .bytePortEnable, .cpuClockStop, .arrayStrobe, .arrayOp, .arrayAddr, .flashTimingValue,
	.programCycles, .eraseCycles);

// File: verif/fpt_flash_guard_tb.sv
// Self-checking bench of the flash guard block.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fpt_flash_guard_tb
	import fpt_pkg::*;
;
	localparam fpt_source_t CPU = FPT_SRC_CPU, SER = FPT_SRC_SERIAL;
	localparam fpt_op_t RD = FPT_OP_READ, PG = FPT_OP_PROGRAM, PE = FPT_OP_PAGE_ERASE, ME = FPT_OP_MASS_ERASE;
	logic clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, regWrite = 1'b0, reqValid = 1'b0;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, reqWdata = 8'h00, regRdata, arrayWdata, lastData;
	fpt_source_t regSource = FPT_SRC_CPU;
	fpt_op_t reqOp = FPT_OP_READ, arrayOp, lastOp;
	logic [15:0] reqAddr = 16'h0000, arrayAddr, flashTimingValue, programCycles, lastAddr;
	logic wholeMemoryGuardBit = 1'b1, lowerHalfGuardBit = 1'b1, serialModeActive = 1'b0, bytePortEnable = 1'b0;
	logic [27:0] bytePortPins = 28'h0000000;
	logic reqAccept, reqDropped, cpuClockStop, arrayStrobe, arrayInfo, lastInfo;
	logic [23:0] eraseCycles;
	int count, n_mismatch = 0, n_tests = 0;
	always #5 clk = ~clk;
	fpt_flash_guard #(.PIN_W(28)) fpt_flash_guard_inst (.clk, .rst_n, .clkEn, .regWrite, .regAddr, .regWdata,
		.regSource, .regRdata, .reqValid, .reqOp, .reqAddr, .reqWdata, .reqAccept, .reqDropped, .wholeMemoryGuardBit,
		.lowerHalfGuardBit, .serialModeActive, .bytePortEnable, .bytePortPins, .cpuClockStop, .arrayStrobe, .arrayOp,
		.arrayAddr, .arrayWdata, .arrayInfo, .flashTimingValue, .programCycles, .eraseCycles);
	fpt_flash_array_model fpt_flash_array_model_inst (.clk, .rst_n, .arrayStrobe, .arrayOp, .arrayAddr,
		.arrayWdata, .arrayInfo, .count, .lastOp, .lastAddr, .lastData, .lastInfo);
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(negedge clk);
		regWrite = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		regAddr = a;
		#1 `CHK(regRdata, e)
	endtask : rd
	// The strobe lands one edge after the request and the model counts it one edge later.
	task automatic req(input fpt_source_t s, input fpt_op_t o, input logic [15:0] a, input logic e);
		int c;
		@(negedge clk);
		regSource = s;
		reqValid = 1'b1;
		reqOp = o;
		reqAddr = a;
		c = count;
		#1 `CHK(reqAccept, e)
		if (!cpuClockStop) `CHK(reqDropped, !e)
		@(negedge clk);
		reqValid = 1'b0;
		@(negedge clk);
		`CHK(count - c, int'(e))
		if (e) `CHK({lastOp, lastAddr}, {o, a})
	endtask : req
	// Pins settle before the strobe bit rises, since the capture waits for two stages to agree.
	task automatic bp(input fpt_op_t o, input logic i, input logic [15:0] a, input logic e);
		int c;
		@(negedge clk);
		bytePortPins = {1'b0, o, i, 8'h5a, a};
		repeat (6) @(negedge clk);
		c = count;
		bytePortPins[27] = 1'b1;
		repeat (10) @(negedge clk);
		`CHK(count - c, int'(e))
		if (e) `CHK({lastOp, lastInfo, lastData, lastAddr}, {o, i, 8'h5a, a})
		bytePortPins[27] = 1'b0;
		repeat (6) @(negedge clk);
	endtask : bp
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(8'h01, 8'h00);
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h00);
		wr(8'h01, 8'h5e);
		rd(8'h01, 8'h04);
		rd(8'h02, 8'h00);
		$display("test reset done");
	endtask : t_reset
	task automatic t_sector();
		wr(8'h02, 8'h05);
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h00);
		wr(8'h02, 8'h10);
		rd(8'h02, 8'h10);
		wr(8'h01, 8'h5e);
		rd(8'h02, 8'h05);
		wr(8'h02, 8'h00);
		wr(8'h01, 8'h5e);
		rd(8'h02, 8'h05);
		wr(8'h02, 8'h00);
		wr(8'h01, 8'h73);
		wr(8'h01, 8'h8c);
		wr(8'h01, 8'h5e);
		rd(8'h01, 8'h03);
		rd(8'h02, 8'h10);
		wr(8'h01, 8'h00);
		$display("test sector done");
	endtask : t_sector
	task automatic t_timing();
		wr(8'h03, 8'h03);
		wr(8'h04, 8'he8);
		`CHK(flashTimingValue, 16'd1000)
		`CHK({programCycles, eraseCycles}, {16'd30, 24'd10000})
		wr(8'h03, 8'h1f);
		wr(8'h04, 8'h40);
		rd(8'h04, 8'h40);
		`CHK({programCycles, eraseCycles}, {16'd240, 24'd80000})
		clkEn = 1'b0;
		wr(8'h03, 8'h55);
		clkEn = 1'b1;
		rd(8'h03, 8'h1f);
		$display("test timing done");
	endtask : t_timing
	task automatic t_cpu();
		wr(8'h02, 8'h20);
		req(CPU, PG, 16'h4000, 1'b0);
		req(CPU, PE, 16'h4000, 1'b0);
		req(SER, PG, 16'h4000, 1'b1);
		req(SER, PE, 16'h4000, 1'b1);
		wr(8'h02, 8'h10);
		req(CPU, PG, 16'h2000, 1'b1);
		wholeMemoryGuardBit = 1'b0;
		lowerHalfGuardBit = 1'b0;
		req(CPU, RD, 16'h0000, 1'b1);
		req(CPU, ME, 16'h0000, 1'b0);
		wr(8'h01, 8'h5e);
		wr(8'h02, 8'h80);
		req(CPU, PG, 16'he000, 1'b0);
		req(CPU, PG, 16'hc000, 1'b1);
		wr(8'h02, 8'h83);
		req(CPU, PG, 16'h00c0, 1'b0);
		req(CPU, RD, 16'h00c0, 1'b0);
		$display("test cpu done");
	endtask : t_cpu
	task automatic t_serial();
		req(SER, RD, 16'h00c0, 1'b1);
		req(SER, PG, 16'h00c0, 1'b0);
		wholeMemoryGuardBit = 1'b1;
		req(SER, PE, 16'h00c0, 1'b0);
		lowerHalfGuardBit = 1'b1;
		req(SER, PG, 16'h00c0, 1'b1);
		req(SER, ME, 16'h00c0, 1'b0);
		wr(8'h02, 8'h10);
		req(SER, ME, 16'h0000, 1'b1);
		lowerHalfGuardBit = 1'b0;
		req(SER, RD, 16'h1000, 1'b0);
		req(SER, RD, 16'h9000, 1'b1);
		wholeMemoryGuardBit = 1'b0;
		req(SER, RD, 16'h9000, 1'b0);
		$display("test serial done");
	endtask : t_serial
	task automatic t_byte();
		serialModeActive = 1'b1;
		bytePortEnable = 1'b1;
		#1 `CHK(cpuClockStop, 1'b1)
		req(CPU, RD, 16'h2000, 1'b0);
		bp(ME, 1'b0, 16'h0000, 1'b1);
		bp(RD, 1'b0, 16'h9000, 1'b0);
		bp(RD, 1'b1, 16'h00c0, 1'b1);
		wholeMemoryGuardBit = 1'b1;
		bp(PG, 1'b0, 16'h1000, 1'b0);
		bp(PG, 1'b0, 16'h9000, 1'b1);
		bp(PG, 1'b1, 16'h00c0, 1'b0);
		lowerHalfGuardBit = 1'b1;
		bp(RD, 1'b0, 16'h1000, 1'b1);
		bp(PG, 1'b1, 16'h00c0, 1'b1);
		bytePortEnable = 1'b0;
		#1 `CHK(cpuClockStop, 1'b0)
		$display("test byte port done");
	endtask : t_byte
	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		t_reset();
		t_sector();
		t_timing();
		t_cpu();
		t_serial();
		t_byte();
		final_report();
	end
	// The sequence needs well under a thousand cycles, so twenty times that means a hang.
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		final_report();
	end
endmodule : fpt_flash_guard_tb
